// file: src/icn_pkg.sv
`default_nettype none
package icn_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int PIN_COUNT  = 22;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 8;
  localparam int HIGH_PINS  = PIN_COUNT - DATA_W;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PULL_LOW    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PULL_HIGH   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STAT_LOW    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT_HIGH   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK_LOW    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK_HIGH   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_LOW   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_HIGH  = 8'h24;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PIN_COUNT-1:0] RST_PINS = 22'h000000;
  localparam logic [DATA_W-1:0]    RST_DATA = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } icn_bus_req_t;

endpackage

`default_nettype wire

// file: src/icn_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Two-stage synchroniser, one lane per pin
// ****************************************
module icn_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta    <= '0;
      syncOut <= '0;
    end else begin
      meta    <= asyncIn;
      syncOut <= meta;
    end
  end

endmodule

`default_nettype wire

// file: src/input_change_notifier.sv
// Function
// [RULE_01] Enabled pin level change raises interrupt request; changeIrq here also needs the pin's changeMask bit set
// [RULE_02] Change detection works with clocks stopped
// [RULE_03] Up to 22 inputs, numbered from zero
// [RULE_04] Per-pin interrupt enable in two registers
// [RULE_05] Per-pin weak pull-up in two registers
// [RULE_06] Software disables pull-up on output pins
// [RULE_07] OR of enabled pin mismatches forms request
`timescale 1ns/100ps
`default_nettype none

module input_change_notifier (
  input  wire logic                           core_clk,
  input  wire logic                           arst_n,
  input  wire logic [icn_pkg::PIN_COUNT-1:0]  pinLevel,
  input  wire icn_pkg::icn_bus_req_t          busReq,
  output var  logic [icn_pkg::DATA_W-1:0]     busRdata,
  output var  logic [icn_pkg::PIN_COUNT-1:0]  weakPullupEnable,
  output var  logic                           changeIrq,
  output var  logic                           wakeRequest
);

  // ****************************************
  // Pin capture
  // ****************************************
  logic [icn_pkg::PIN_COUNT-1:0] syncLevel;
  logic [icn_pkg::PIN_COUNT-1:0] lastLevel;
  logic [icn_pkg::PIN_COUNT-1:0] irqEnable;
  logic [icn_pkg::PIN_COUNT-1:0] changeStatus;
  logic [icn_pkg::PIN_COUNT-1:0] changeMask;
  logic [icn_pkg::PIN_COUNT-1:0] levelTransition;
  logic [icn_pkg::PIN_COUNT-1:0] clearStatus;
  logic [icn_pkg::PIN_COUNT-1:0] rawMismatch;
  logic                          asyncHit;

  // Raw levels pass two flops before status and read logic see them; the wakeRequest preset takes them raw
  icn_sync #(
    .WIDTH (icn_pkg::PIN_COUNT)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .asyncIn  (pinLevel),
    .syncOut  (syncLevel)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastLevel <= icn_pkg::RST_PINS;
    end else begin
      lastLevel <= syncLevel;
    end
  end

  // ****************************************
  // Change detection
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < icn_pkg::PIN_COUNT; gi++) begin : g_pin // [RULE_03]
      assign levelTransition[gi] = irqEnable[gi]
                                 & (syncLevel[gi] ^ lastLevel[gi]); // [RULE_04]
      // Raw path needs no clock; compared against last clocked level
      assign rawMismatch[gi] = irqEnable[gi]
                             & (pinLevel[gi] ^ lastLevel[gi]); // [RULE_02]
    end
  endgenerate

  // Short pulses on an enabled pin still wake, even if status misses them
  assign asyncHit = |rawMismatch; // [RULE_07]

  // ****************************************
  // Register write port
  // ****************************************
  // Writes to high halves ignore bits above the last pin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnable        <= icn_pkg::RST_PINS;
      weakPullupEnable <= icn_pkg::RST_PINS;
      changeMask       <= icn_pkg::RST_PINS;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        icn_pkg::OFS_IRQ_EN_LOW: begin
          irqEnable[icn_pkg::DATA_W-1:0] <= busReq.wdata; // [RULE_04]
        end
        icn_pkg::OFS_IRQ_EN_HIGH: begin
          irqEnable[icn_pkg::PIN_COUNT-1:icn_pkg::DATA_W] <=
            busReq.wdata[icn_pkg::HIGH_PINS-1:0]; // [RULE_04]
        end
        icn_pkg::OFS_PULL_LOW: begin
          weakPullupEnable[icn_pkg::DATA_W-1:0] <= busReq.wdata; // [RULE_05]
        end
        icn_pkg::OFS_PULL_HIGH: begin
          weakPullupEnable[icn_pkg::PIN_COUNT-1:icn_pkg::DATA_W] <=
            busReq.wdata[icn_pkg::HIGH_PINS-1:0]; // [RULE_05]
        end
        icn_pkg::OFS_MASK_LOW: begin
          changeMask[icn_pkg::DATA_W-1:0] <= busReq.wdata;
        end
        icn_pkg::OFS_MASK_HIGH: begin
          changeMask[icn_pkg::PIN_COUNT-1:icn_pkg::DATA_W] <=
            busReq.wdata[icn_pkg::HIGH_PINS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Sticky status, write one to clear
  // ****************************************
  always_comb begin
    clearStatus = icn_pkg::RST_PINS;
    if (busReq.wr && busReq.addr == icn_pkg::OFS_STAT_LOW) begin
      clearStatus[icn_pkg::DATA_W-1:0] = busReq.wdata;
    end
    if (busReq.wr && busReq.addr == icn_pkg::OFS_STAT_HIGH) begin
      clearStatus[icn_pkg::PIN_COUNT-1:icn_pkg::DATA_W] =
        busReq.wdata[icn_pkg::HIGH_PINS-1:0];
    end
  end

  // A change in the clearing cycle survives: set beats clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      changeStatus <= icn_pkg::RST_PINS;
    end else begin
      changeStatus <= (changeStatus & ~clearStatus) | levelTransition; // [RULE_01]
    end
  end

  // Registered so the request never glitches while software clears bits
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      changeIrq <= 1'b0;
    end else begin
      changeIrq <= |(changeStatus & changeMask); // [RULE_07]
    end
  end

  // ****************************************
  // Clockless wake request
  // ****************************************
  // Preset by the raw mismatch so Sleep needs no edge; once clocks
  // run it follows the synchronised view and drops with the change
  always_ff @(posedge core_clk or negedge arst_n or posedge asyncHit) begin
    if (!arst_n) begin
      wakeRequest <= 1'b0;
    end else if (asyncHit) begin
      wakeRequest <= 1'b1; // [RULE_02]
    end else begin
      wakeRequest <= |levelTransition; // [RULE_01]
    end
  end

  // ****************************************
  // Register read views
  // ****************************************
  // High halves widen with zeros, so bits above the last pin read 0
  localparam int DW = icn_pkg::DATA_W;
  localparam int PC = icn_pkg::PIN_COUNT;

  logic [DW-1:0] irqEnableHigh;
  logic [DW-1:0] pullupHigh;
  logic [DW-1:0] statusHigh;
  logic [DW-1:0] maskHigh;
  logic [DW-1:0] levelHigh;

  assign irqEnableHigh = DW'(irqEnable[PC-1:DW]);
  assign pullupHigh    = DW'(weakPullupEnable[PC-1:DW]);
  assign statusHigh    = DW'(changeStatus[PC-1:DW]);
  assign maskHigh      = DW'(changeMask[PC-1:DW]);
  assign levelHigh     = DW'(syncLevel[PC-1:DW]); // [RULE_03]

  // ****************************************
  // Register read port
  // ****************************************
  // Data stand for one cycle only; idle cycles read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= icn_pkg::RST_DATA;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        icn_pkg::OFS_IRQ_EN_LOW: begin
          busRdata <= irqEnable[DW-1:0]; // [RULE_04]
        end
        icn_pkg::OFS_IRQ_EN_HIGH: begin
          busRdata <= irqEnableHigh; // [RULE_04]
        end
        icn_pkg::OFS_PULL_LOW: begin
          busRdata <= weakPullupEnable[DW-1:0]; // [RULE_05]
        end
        icn_pkg::OFS_PULL_HIGH: begin
          busRdata <= pullupHigh; // [RULE_05]
        end
        icn_pkg::OFS_STAT_LOW: begin
          busRdata <= changeStatus[DW-1:0];
        end
        icn_pkg::OFS_STAT_HIGH: begin
          busRdata <= statusHigh;
        end
        icn_pkg::OFS_MASK_LOW: begin
          busRdata <= changeMask[DW-1:0];
        end
        icn_pkg::OFS_MASK_HIGH: begin
          busRdata <= maskHigh;
        end
        icn_pkg::OFS_LEVEL_LOW: begin
          busRdata <= syncLevel[DW-1:0];
        end
        icn_pkg::OFS_LEVEL_HIGH: begin
          busRdata <= levelHigh;
        end
        default: begin
          busRdata <= icn_pkg::RST_DATA;
        end
      endcase
    end else begin
      busRdata <= icn_pkg::RST_DATA;
    end
  end

endmodule

`default_nettype wire

// file: sim/icn_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module icn_monitor (
  input wire logic                  core_clk,
  input wire logic                  arst_n,
  input wire logic [21:0]           pinLevel,
  input wire icn_pkg::icn_bus_req_t busReq,
  input wire logic [15:0]           busRdata,
  input wire logic [21:0]           weakPullupEnable,
  input wire logic                  changeIrq,
  input wire logic                  wakeRequest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic wrPl = busReq.wr && busReq.addr == icn_pkg::OFS_PULL_LOW;
  wire logic wrPh = busReq.wr && busReq.addr == icn_pkg::OFS_PULL_HIGH;
  wire logic rdPh = busReq.rd && busReq.addr == icn_pkg::OFS_PULL_HIGH;
  property p_pull_lo;
    wrPl |=> weakPullupEnable[15:0] == $past(busReq.wdata);
  endproperty
  a_pull_lo: assert property (p_pull_lo)
    else $error("pull low");
  property p_pull_hi;
    wrPh |=> weakPullupEnable[21:16] == $past(busReq.wdata[5:0]);
  endproperty
  a_pull_hi: assert property (p_pull_hi)
    else $error("pull high");
  property p_pull_hold;
    !(wrPl || wrPh) |=> $stable(weakPullupEnable);
  endproperty
  a_pull_hold: assert property (p_pull_hold)
    else $error("pull drift");
  property p_hi_rd;
    rdPh |=> busRdata == {10'h000, $past(weakPullupEnable[21:16])};
  endproperty
  a_hi_rd: assert property (p_hi_rd)
    else $error("high read");
  // Wake must settle once pins are quiet, or sleep would never end
  property p_wake;
    $stable(pinLevel) [*6] |-> !wakeRequest;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake stuck");
  property p_irq_cause;
    $rose(changeIrq) |-> $past(busReq.wr, 2)
      || $past(pinLevel, 3) != $past(pinLevel, 5);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq cause");
  property p_irq_fall;
    $fell(changeIrq) |-> $past(busReq.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq drop");
  c_irq: cover property ($rose(changeIrq));
  c_wake: cover property ($rose(wakeRequest));
  c_hi: cover property (rdPh);
endmodule
`default_nettype wire

// file: sim/icn_button_model.sv
`timescale 1ns/100ps
`default_nettype none
module icn_button_model (
  input  wire logic        core_clk,
  input  wire logic [21:0] pressed,
  input  wire logic [21:0] weakPullupEnable,
  output var  logic [21:0] pinLevel
);
  logic [21:0] drift = 22'h000000;
  // A released pin without pull-up floats, so it must not look steady
  always_ff @(posedge core_clk) drift <= ~drift;
  always_comb pinLevel = ~pressed & (weakPullupEnable | drift);
endmodule
`default_nettype wire

// file: sim/test_input_change_notifier.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,a) begin totalChecks++; \
  if ((e) !== (a)) begin nErrors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module test_input_change_notifier;
  logic                  core_clk = 1'b0;
  logic                  arst_n = 1'b0;
  icn_pkg::icn_bus_req_t busReq = '0;
  logic [15:0]           busRdata, expRd, expQ[$];
  logic [21:0]           pinLevel, weakPullupEnable, pressed = '0;
  logic                  changeIrq, wakeRequest, rdSeen = 1'b0;
  logic [31:0]           seed = 32'h0270E31A;
  int                    nErrors = 0, totalChecks = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  input_change_notifier dut (.core_clk(core_clk), .arst_n(arst_n),
    .pinLevel(pinLevel), .busReq(busReq), .busRdata(busRdata),
    .weakPullupEnable(weakPullupEnable), .changeIrq(changeIrq),
    .wakeRequest(wakeRequest));
  icn_button_model pads (.core_clk(core_clk), .pressed(pressed),
    .weakPullupEnable(weakPullupEnable), .pinLevel(pinLevel));
  task automatic conclude;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A hung run counts a mismatch and still reaches the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      conclude();
    end
  end
  always @(posedge core_clk) begin
    if (rdSeen) begin
      expRd = expQ.pop_front();
      `CHK("rdata", expRd, busRdata)
    end
    rdSeen <= busReq.rd;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    if (!w) expQ.push_back(d);
    busReq <= '{a, d, w, !w};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    busReq.rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pin(input int q, input logic en, input logic msk);
    logic [7:0]  o;
    logic [15:0] b;
    o = q < 16 ? 8'h00 : 8'h04;
    b = 16'h0001 << (q % 16);
    bus(1, icn_pkg::OFS_IRQ_EN_LOW + o, en ? b : 16'h0000);
    bus(1, icn_pkg::OFS_MASK_LOW + o, msk ? b : 16'h0000);
    pressed[q] <= 1'b1;
    #1 `CHK("wake", en, wakeRequest)
    tick(6);
    `CHK("irq", en & msk, changeIrq)
    bus(0, icn_pkg::OFS_STAT_LOW + o, en ? b : 16'h0000);
    pressed[q] <= 1'b0;
    tick(6);
    bus(1, icn_pkg::OFS_STAT_LOW + o, b);
    tick(2);
    `CHK("irq clear", 1'b0, changeIrq)
    $display("test pin %0d done", q);
  endtask
  initial begin
    tick(10);
    arst_n <= 1'b1;
    tick(1);
    for (int a = 0; a < 8'h2C; a += 4) begin
      if (a < 8'h20 || a > 8'h24) begin
        bus(0, a[7:0], 16'h0000);
      end
    end
    $display("test reset done");
    repeat (2) begin
      seed = lfsr(seed);
      bus(1, icn_pkg::OFS_PULL_LOW, seed[15:0]);
      bus(1, icn_pkg::OFS_PULL_HIGH, seed[31:16]);
      `CHK("pull", seed[21:0], weakPullupEnable)
      bus(0, icn_pkg::OFS_PULL_HIGH, {10'h000, seed[21:16]});
    end
    // Every pin stays an input here, so all pulls may be on
    bus(1, icn_pkg::OFS_PULL_LOW, 16'hFFFF);
    bus(1, icn_pkg::OFS_PULL_HIGH, 16'h003F);
    tick(3);
    bus(0, icn_pkg::OFS_LEVEL_HIGH, 16'h003F);
    $display("test pull done");
    foreach (seed[i]) begin
      if (i == 0 || i == 15 || i == 16 || i == 21) begin
        pin(i, 1, 1);
      end
    end
    pin(1, 0, 1);
    pin(2, 1, 0);
    conclude();
  end
endmodule
bind input_change_notifier icn_monitor mon (.core_clk(core_clk),
  .arst_n(arst_n), .pinLevel(pinLevel), .busReq(busReq),
  .busRdata(busRdata), .weakPullupEnable(weakPullupEnable),
  .changeIrq(changeIrq), .wakeRequest(wakeRequest));
`default_nettype wire
